// file: aocp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module aocp_ctrl
  import aocp_pkg::*;
#(
  // shorten to a few cycles in simulation
  parameter int US_CYCLES = US_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic cfg_wr_i,
  input wire aocp_cfg_s cfg_i,
  input wire logic cin_mode_i,
  input wire logic alarm_clr_i,
  // analog comparators, asynchronous
  input wire logic ovl_cmp_i,
  input wire logic short_cmp_i,
  input wire logic cin_oc_cmp_i,
  // output stage control
  output logic [1:0] ovl_thr_sel_o,
  output logic hiz_o,
  output logic cur_mode_o,
  output logic [LW-1:0] limit_cur_o,
  output logic input_current_switch_open_o,
  // alarm and status
  output logic alarm_o,
  output aocp_status_s status_o
);
  localparam int NIN = 3;

  aocp_cfg_s cfg_ff, nxt_cfg;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] filt_ff, nxt_filt;
  logic [SYNC_N-1:0] sync_ff [NIN];
  logic ovl_f, short_f, coc_f;
  aocp_state_e state_ff, nxt_state;
  logic alarm_ff, nxt_alarm;
  logic hiz_ff, nxt_hiz;
  logic cur_ff, nxt_cur;
  logic open_ff, nxt_open;
  logic short_seen_ff, nxt_short_seen;
  logic ovl_fault_ff, nxt_ovl_fault;
  logic [LW-1:0] lim_ff, nxt_lim;
  logic tmr_clear, tmr_done, cin_clear, cin_done;
  aocp_us_t tmr_target;

  assign raw = {cin_oc_cmp_i, short_cmp_i, ovl_cmp_i};

  // three stages; a change is taken once stages two and three agree
  for (genvar i = 0; i < NIN; i++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync_ff[i] <= '0;
      end else begin
        sync_ff[i] <= {sync_ff[i][SYNC_N-2:0], raw[i]};
      end
    end
  end

  // one process drives the whole filtered vector
  always_comb begin
    nxt_filt = filt_ff;
    for (int j = 0; j < NIN; j++) begin
      if (sync_ff[j][1] == sync_ff[j][2]) begin
        nxt_filt[j] = sync_ff[j][2];
      end
    end
  end

  assign ovl_f = filt_ff[0];
  assign short_f = filt_ff[1];
  assign coc_f = filt_ff[2];

  // settings are shadowed so reset brings every one back to its default
  always_comb begin
    nxt_cfg = cfg_ff;
    if (cfg_wr_i) begin
      nxt_cfg = cfg_i;
    end
  end

  always_comb begin
    tmr_target = rct_us(cfg_ff.rct_sel);
    unique case (state_ff)
      ST_DEGL: tmr_target = dgl_us(cfg_ff.dgl_sel);
      ST_LIMIT: tmr_target = per_us(cfg_ff.per_sel);
      default: tmr_target = rct_us(cfg_ff.rct_sel);
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_alarm = alarm_ff;
    nxt_short_seen = short_seen_ff;
    nxt_ovl_fault = ovl_fault_ff;
    nxt_open = open_ff;
    if (alarm_clr_i) begin
      nxt_alarm = 1'b0;
      nxt_short_seen = 1'b0;
      nxt_ovl_fault = 1'b0;
      nxt_open = 1'b0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (!cin_mode_i && ovl_f) begin
          nxt_state = ST_DEGL;
        end
      end
      ST_DEGL: begin
        if (!ovl_f || cin_mode_i) begin
          nxt_state = ST_IDLE;
        end else if (tmr_done) begin
          nxt_state = ST_REACT;
        end
      end
      ST_REACT: begin
        if (!ovl_f || cin_mode_i) begin
          nxt_state = ST_IDLE;
        end else if (tmr_done) begin
          if (cfg_ff.lim_en) begin
            nxt_state = ST_SETTLE;
          end else begin
            nxt_state = ST_HIZ;
            nxt_alarm = 1'b1;
            nxt_ovl_fault = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          if (ovl_f) begin
            nxt_state = ST_HIZ;
            nxt_alarm = 1'b1;
            nxt_ovl_fault = 1'b1;
          end else begin
            nxt_state = ST_LIMIT;
          end
        end
      end
      ST_LIMIT: begin
        if (cfg_ff.per_sel != PER_INFINITE && tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_HIZ: begin
        // high impedance is held until software clears the alarm
        if (alarm_clr_i && !short_f) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // short circuit wins over every other step
    if (!cin_mode_i && short_f) begin
      nxt_state = ST_HIZ;
      nxt_alarm = 1'b1;
      nxt_short_seen = 1'b1;
    end
    // open the switch on lasting overcurrent
    if (cin_done) begin
      nxt_open = 1'b1;
      nxt_alarm = 1'b1;
    end
  end

  assign tmr_clear = (nxt_state != state_ff);
  // the switch timer is held clear while overcurrent is absent
  assign cin_clear = !(cin_mode_i && coc_f) || open_ff;

  always_comb begin
    nxt_hiz = (nxt_state == ST_HIZ);
    // current mode from settling through the limiter period
    nxt_cur = (nxt_state == ST_SETTLE) || (nxt_state == ST_LIMIT);
    // shadow value, clamped below the ceiling
    nxt_lim = (cfg_ff.lim_cur > LIM_MAX) ? LIM_MAX : cfg_ff.lim_cur;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_DEFAULT;
      filt_ff <= '0;
      state_ff <= ST_IDLE;
      alarm_ff <= 1'b0;
      hiz_ff <= 1'b0;
      cur_ff <= 1'b0;
      open_ff <= 1'b0;
      short_seen_ff <= 1'b0;
      ovl_fault_ff <= 1'b0;
      lim_ff <= LIM_MAX;
    end else begin
      cfg_ff <= nxt_cfg;
      filt_ff <= nxt_filt;
      state_ff <= nxt_state;
      alarm_ff <= nxt_alarm;
      hiz_ff <= nxt_hiz;
      cur_ff <= nxt_cur;
      open_ff <= nxt_open;
      short_seen_ff <= nxt_short_seen;
      ovl_fault_ff <= nxt_ovl_fault;
      lim_ff <= nxt_lim;
    end
  end

  aocp_timer #(.US_CYCLES(US_CYCLES)) u_main_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(tmr_clear),
    .target_i(tmr_target),
    .done_o(tmr_done)
  );

  aocp_timer #(.US_CYCLES(US_CYCLES)) u_cin_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(cin_clear),
    .target_i(cin_us(cfg_ff.cin_sel)),
    .done_o(cin_done)
  );

  // threshold code to the slow comparator
  assign ovl_thr_sel_o = cfg_ff.thr_sel;
  assign hiz_o = hiz_ff;
  assign cur_mode_o = cur_ff;
  assign limit_cur_o = lim_ff;
  assign input_current_switch_open_o = open_ff;
  assign alarm_o = alarm_ff;
  assign status_o = '{state: state_ff, short_seen: short_seen_ff, ovl_fault: ovl_fault_ff,
    cin_open: open_ff, cur_mode: cur_ff};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_react_default: assert property ($past(rst_i) |-> cfg_ff.rct_sel == RCT_SEL_DEF)
    else $error("reaction time not at default after reset");
  chk_limit_reset: assert property ($past(rst_i) |-> cfg_ff.lim_cur == LIM_DEFAULT && !cfg_ff.lim_en)
    else $error("shadow limit or response not at default after reset");
  chk_degl_restart: assert property (state_ff == ST_DEGL && !ovl_f && !short_f |=> state_ff == ST_IDLE)
    else $error("deglitch did not restart on drop");
  chk_degl_early: assert property ($rose(state_ff == ST_REACT) |-> $past(tmr_done))
    else $error("reaction entered before deglitch expiry");
  chk_hiz_resp: assert property (state_ff == ST_REACT && tmr_done && ovl_f && !cin_mode_i && !cfg_ff.lim_en
    |=> state_ff == ST_HIZ ##1 hiz_o && alarm_o)
    else $error("default response is not high impedance");
  chk_limit_engage: assert property (state_ff == ST_REACT && tmr_done && ovl_f && !cin_mode_i && cfg_ff.lim_en
    && !short_f |=> ##1 cur_mode_o && limit_cur_o <= LIM_MAX)
    else $error("limiter not engaged");
  chk_settle_fail: assert property (state_ff == ST_SETTLE && tmr_done && ovl_f |=> ##1 hiz_o && alarm_o
    && status_o.ovl_fault)
    else $error("settle failure did not force high impedance");
  chk_period_end: assert property (state_ff == ST_LIMIT && tmr_done && cfg_ff.per_sel != PER_INFINITE
    && !short_f |=> ##1 !cur_mode_o)
    else $error("limiter period end did not restore voltage mode");
  chk_short_hiz: assert property ($rose(short_f) && !cin_mode_i |-> ##2 hiz_o)
    else $error("short did not force high impedance");
  chk_cin_open: assert property (cin_done |=> input_current_switch_open_o && alarm_o)
    else $error("input current switch did not open");
  chk_alarm_sticky: assert property (alarm_o && !alarm_clr_i |=> alarm_o)
    else $error("alarm dropped without clear");

  cov_limit_run: cover property (state_ff == ST_SETTLE ##1 state_ff == ST_LIMIT);
  cov_settle_hiz: cover property (state_ff == ST_SETTLE ##1 state_ff == ST_HIZ);
  cov_short: cover property ($rose(short_seen_ff));
  cov_cin_open: cover property ($rose(input_current_switch_open_o));
endmodule
`default_nettype wire

// file: aocp_pkg.sv
// What this block does
// - The slow overload comparator threshold is one of four levels, 5, 10, 20 or 25 mA magnitude.
// - An overload shorter than the deglitch time of 10, 20, 50 or 100 us is ignored.
// - The reaction time after the deglitched overload is 25, 50, 100 or 200 us and resets to 25 us.
// - A config bit picks the response to a lasting overload, high impedance by default or the current limiter.
// - With the limiter picked and overload still present after the reaction time, the stage goes to current mode below 25 mA.
// - The limiter current comes from a user written shadow value that resets to 25 mA.
// - Overload still present after the settling time in limiter mode forces high impedance, alarm and status update.
// - Overload gone after the settling time keeps the limiter current for an infinite or 1, 2, 5 or 10 ms period.
// - When a finite limiter period ends the output stage returns to voltage mode.
// - Outside current input mode the fast short circuit detector forces the output to high impedance at once.
// - In current input mode the input current switch opens once overcurrent lasts a chosen 50 us to 10 ms.
package aocp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  // cycles per microsecond tick, rounded up so no interval runs short
  localparam int US_CYCLES_DEF = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW = 14;
  localparam int LW = 9;
  localparam int SYNC_N = 3;
  typedef logic [TW-1:0] aocp_us_t;
  // limiter current in 0.1 mA units
  localparam logic [LW-1:0] LIM_DEFAULT = 9'h0FA;
  localparam logic [LW-1:0] LIM_MAX = 9'h0F9;
  localparam logic [1:0] THR_SEL_DEF = 2'h3;
  localparam logic [1:0] DGL_SEL_DEF = 2'h0;
  localparam logic [1:0] RCT_SEL_DEF = 2'h0;
  localparam logic [2:0] PER_INFINITE = 3'h0;
  localparam logic [2:0] CIN_SEL_DEF = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEGL = 3'b001,
    ST_REACT = 3'b010,
    ST_SETTLE = 3'b011,
    ST_LIMIT = 3'b100,
    ST_HIZ = 3'b101
  } aocp_state_e;

  typedef struct packed {
    logic [1:0] thr_sel;
    logic [1:0] dgl_sel;
    logic [1:0] rct_sel;
    logic lim_en;
    logic [2:0] per_sel;
    logic [2:0] cin_sel;
    logic [LW-1:0] lim_cur;
  } aocp_cfg_s;

  localparam aocp_cfg_s CFG_DEFAULT = '{thr_sel: THR_SEL_DEF, dgl_sel: DGL_SEL_DEF, rct_sel: RCT_SEL_DEF,
    lim_en: 1'b0, per_sel: PER_INFINITE, cin_sel: CIN_SEL_DEF, lim_cur: LIM_DEFAULT};

  typedef struct packed {
    logic [2:0] state;
    logic short_seen;
    logic ovl_fault;
    logic cin_open;
    logic cur_mode;
  } aocp_status_s;

  function automatic aocp_us_t dgl_us(input logic [1:0] s);
    unique case (s)
      2'h0: dgl_us = 14'h000A;
      2'h1: dgl_us = 14'h0014;
      2'h2: dgl_us = 14'h0032;
      default: dgl_us = 14'h0064;
    endcase
  endfunction

  function automatic aocp_us_t rct_us(input logic [1:0] s);
    unique case (s)
      2'h0: rct_us = 14'h0019;
      2'h1: rct_us = 14'h0032;
      2'h2: rct_us = 14'h0064;
      default: rct_us = 14'h00C8;
    endcase
  endfunction

  // code 0 is infinite and never timed
  function automatic aocp_us_t per_us(input logic [2:0] s);
    unique case (s)
      3'h1: per_us = 14'h03E8;
      3'h2: per_us = 14'h07D0;
      3'h3: per_us = 14'h1388;
      default: per_us = 14'h2710;
    endcase
  endfunction

  function automatic aocp_us_t cin_us(input logic [2:0] s);
    unique case (s)
      3'h0: cin_us = 14'h0032;
      3'h1: cin_us = 14'h0064;
      3'h2: cin_us = 14'h00C8;
      3'h3: cin_us = 14'h01F4;
      3'h4: cin_us = 14'h03E8;
      3'h5: cin_us = 14'h07D0;
      3'h6: cin_us = 14'h1388;
      default: cin_us = 14'h2710;
    endcase
  endfunction
endpackage

// file: aocp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module aocp_timer
  import aocp_pkg::*;
#(
  parameter int US_CYCLES = US_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire aocp_us_t target_i,
  // result
  output logic done_o
);
  logic [15:0] pre_ff, nxt_pre;
  aocp_us_t cnt_ff, nxt_cnt;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_cnt = cnt_ff;
    if (clear_i) begin
      nxt_pre = '0;
      nxt_cnt = '0;
    end else if (!done_o) begin
      if (pre_ff == 16'(US_CYCLES - 1)) begin
        nxt_pre = '0;
        nxt_cnt = cnt_ff + 1'b1;
      end else begin
        nxt_pre = pre_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_ff <= '0;
      cnt_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
    end
  end

  // done must not look at clear_i: the caller derives clear_i from done_o, so that would close a loop;
  // a state change clears the count at the same edge, so a new interval never starts with a stale done
  assign done_o = (cnt_ff >= target_i);
endmodule
`default_nettype wire

// file: aocp_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module aocp_stage_model
  import aocp_pkg::*;
(
  // stage control from the block
  input wire logic [1:0] ovl_thr_sel_i,
  input wire logic hiz_i,
  input wire logic cur_mode_i,
  input wire logic [LW-1:0] limit_cur_i,
  // load demand and input current, 0.1 ma units
  input wire logic [LW:0] load_i,
  input wire logic [LW:0] cin_load_i,
  // comparator levels
  output logic ovl_cmp_o,
  output logic short_cmp_o,
  output logic cin_oc_cmp_o
);
  logic [LW:0] out_cur;
  logic [LW:0] thr;
  always_comb begin
    // a high impedance stage carries no current, so the overload and short comparators drop
    out_cur = hiz_i ? '0 : load_i;
    // current mode caps what the load can draw
    if (cur_mode_i && !hiz_i && load_i > {1'b0, limit_cur_i}) begin
      out_cur = {1'b0, limit_cur_i};
    end
    case (ovl_thr_sel_i)
      2'h0: thr = 10'h032;
      2'h1: thr = 10'h064;
      2'h2: thr = 10'h0c8;
      default: thr = 10'h0fa;
    endcase
  end
  assign ovl_cmp_o = out_cur > thr;
  assign short_cmp_o = out_cur > 10'h2bc;
  assign cin_oc_cmp_o = cin_load_i > 10'h0fa;
endmodule
`default_nettype wire

// file: aocp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("mismatch %0t %s", $time, msg); end end
module aocp_ctrl_tb;
  import aocp_pkg::*;
  localparam int US = 1;
  localparam int LIMIT_CYC = 60000;
  int dgl_t[4] = '{10, 20, 50, 100};
  int rct_t[4] = '{25, 50, 100, 200};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic cin_mode_i = 1'b0;
  logic alarm_clr_i = 1'b0;
  aocp_cfg_s cfg_i = CFG_DEFAULT;
  logic [LW:0] load = '0;
  logic [LW:0] cin_load = '0;
  logic ovl, shrt, cin_oc, hiz_o, cur_mode_o, sw_open, alarm_o;
  logic [1:0] ovl_thr_sel_o;
  logic [LW-1:0] limit_cur_o;
  aocp_status_s status_o;

  aocp_ctrl #(.US_CYCLES(US)) aocp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
    .cin_mode_i(cin_mode_i), .alarm_clr_i(alarm_clr_i), .ovl_cmp_i(ovl), .short_cmp_i(shrt),
    .cin_oc_cmp_i(cin_oc), .ovl_thr_sel_o(ovl_thr_sel_o), .hiz_o(hiz_o), .cur_mode_o(cur_mode_o),
    .limit_cur_o(limit_cur_o), .input_current_switch_open_o(sw_open), .alarm_o(alarm_o), .status_o(status_o));
  aocp_stage_model aocp_stage_model_i (.ovl_thr_sel_i(ovl_thr_sel_o), .hiz_i(hiz_o), .cur_mode_i(cur_mode_o),
    .limit_cur_i(limit_cur_o), .load_i(load), .cin_load_i(cin_load), .ovl_cmp_o(ovl), .short_cmp_o(shrt),
    .cin_oc_cmp_o(cin_oc));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, sized well above the longest test sequence
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT_CYC) begin
      n_fail++;
      final_report();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic cfg(input logic [1:0] t, input logic [1:0] d, input logic [1:0] r, input logic le,
    input logic [2:0] p, input logic [2:0] c, input logic [LW-1:0] cur);
    cfg_i = '{thr_sel: t, dgl_sel: d, rct_sel: r, lim_en: le, per_sel: p, cin_sel: c, lim_cur: cur};
    cfg_wr_i = 1'b1;
    tick(1);
    cfg_wr_i = 1'b0;
    tick(2);
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    tick(6);
    rst_i = 1'b0;
    tick(1);
    `CHK({hiz_o, cur_mode_o, alarm_o, sw_open}, 4'h0, "outputs idle after reset")
    `CHK(status_o, 7'h00, "status clear after reset")
    `CHK(limit_cur_o, 9'h0f9, "limiter default")
    `CHK(ovl_thr_sel_o, 2'h3, "threshold default")
  endtask

  // alarm clear with the load gone brings the stage out of high impedance
  task automatic clear();
    load = '0;
    cin_load = '0;
    tick(8);
    alarm_clr_i = 1'b1;
    tick(1);
    alarm_clr_i = 1'b0;
    tick(2);
    `CHK({hiz_o, alarm_o, sw_open}, 3'h0, "clear failed")
  endtask

  function automatic logic hit(input int w);
    case (w)
      0: hit = hiz_o === 1'b1;
      1: hit = cur_mode_o === 1'b1;
      2: hit = cur_mode_o === 1'b0;
      default: hit = sw_open === 1'b1;
    endcase
  endfunction

  task automatic wait_for(input int w, output int cnt);
    cnt = 0;
    while (!hit(w) && cnt < 12000) begin
      tick(1);
      cnt++;
    end
  endtask

  task automatic win(input int got, input int lo, input int hi, input string msg);
    `CHK(got >= lo && got <= hi, 1'b1, msg)
  endtask

  initial begin
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cfg(i[1:0], 2'h0, 2'h0, 1'b0, 3'h0, 3'h7, LIM_DEFAULT);
      `CHK(ovl_thr_sel_o, i[1:0], "threshold code")
    end
    $display("test threshold done");
    // two short overloads: the deglitch count must restart in the gap
    cfg(2'h1, 2'h1, 2'h0, 1'b0, 3'h0, 3'h7, LIM_DEFAULT);
    load = 10'h0c8;
    tick(14);
    load = '0;
    tick(4);
    load = 10'h0c8;
    tick(14);
    load = '0;
    tick(60);
    `CHK(status_o.state, ST_IDLE, "glitch not ignored")
    `CHK(hiz_o, 1'b0, "glitch tripped output")
    $display("test glitch done");
    for (int k = 0; k < 4; k += 3) begin
      cfg(2'h1, k[1:0], k[1:0], 1'b0, 3'h0, 3'h7, LIM_DEFAULT);
      load = 10'h0c8;
      wait_for(0, n);
      win(n, dgl_t[k] + rct_t[k], dgl_t[k] + rct_t[k] + 12, "high impedance timing");
      `CHK({alarm_o, cur_mode_o}, 2'h2, "high impedance response")
      clear();
    end
    $display("test hiz done");
    cfg(2'h1, 2'h0, 2'h0, 1'b1, 3'h1, 3'h7, 9'h096);
    load = 10'h0c8;
    wait_for(1, n);
    `CHK({hiz_o, limit_cur_o}, {1'b0, 9'h096}, "limiter current")
    wait_for(0, n);
    win(n, 25, 37, "settle timing");
    `CHK({alarm_o, status_o.ovl_fault}, 2'h3, "limiter fault")
    clear();
    $display("test limiter fault done");
    cfg(2'h1, 2'h0, 2'h0, 1'b1, 3'h1, 3'h7, 9'h050);
    load = 10'h0c8;
    wait_for(1, n);
    wait_for(2, n);
    win(n, 1025, 1040, "finite period");
    load = '0;
    tick(60);
    `CHK({status_o.state, hiz_o, alarm_o}, {ST_IDLE, 2'h0}, "back to voltage mode")
    $display("test finite period done");
    // shadow above the ceiling is clamped while the limit stays just under 25 ma
    cfg(2'h3, 2'h0, 2'h0, 1'b1, 3'h0, 3'h7, 9'h12c);
    `CHK(limit_cur_o, 9'h0f9, "limiter clamp")
    load = 10'h12c;
    wait_for(1, n);
    tick(3000);
    `CHK({cur_mode_o, status_o.state}, {1'b1, ST_LIMIT}, "infinite period")
    load = '0;
    do_reset();
    $display("test infinite period done");
    load = 10'h320;
    wait_for(0, n);
    win(n, 2, 10, "short reaction");
    `CHK(status_o.short_seen, 1'b1, "short flag")
    clear();
    $display("test short done");
    cin_mode_i = 1'b1;
    cfg(2'h3, 2'h0, 2'h0, 1'b0, 3'h0, 3'h0, LIM_DEFAULT);
    cin_load = 10'h12c;
    tick(30);
    cin_load = '0;
    tick(80);
    `CHK(sw_open, 1'b0, "switch opened early")
    cin_load = 10'h12c;
    wait_for(3, n);
    win(n, 50, 62, "switch open timing");
    `CHK(alarm_o, 1'b1, "switch alarm")
    clear();
    cin_mode_i = 1'b0;
    $display("test current input done");
    final_report();
  end
endmodule
`default_nettype wire
